// ### rtl/rbcm_device.sv
// module: device end, reset domains, straps, boot flows and rom copy
//
// Functional notes
// - core clock from reference, multiplied or bypassed
// - ratio straps: 00 x1, 01 x6, 10 x12
// - controller waits worst PLL lock time
// - both resets asserted at power-up
// - each reset initialises only its domain
// - test reset may stay asserted forever
// - undriven test reset reads asserted
// - debug pins latched on test reset rise
// - core reset release starts configured boot
// - host boot stalls CPU only
// - PCI strap picks host port or PCI
// - doorbell ends host boot, run at 0
// - doorbell not pended, releases only host boot
// - host may read and write all memory
// - CPU clears doorbell before next one
// - ROM boot copies 1K from chip space 1
// - bytes assembled into 32-bit words
// - single block copy then run at 0
// - no-boot runs at 0 after SDRAM init
//
// Our own choices: the strobed register port and the placing of the registers.
`default_nettype none
module rbcm_device #(
  parameter int COPY_BYTES = rbcm_pkg::ROM_COPY_BYTES,
  parameter bit BIG_ENDIAN = 1'b0
) (
  // clock and power-on reset
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  // link to controller
  rbcm_link_if.device      link,
  // rom side of the external memory interface
  output logic [31:0]      rom_addr_out,
  output logic             rom_rd_out,
  input  wire logic [7:0]  rom_data_in,
  // internal memory write port
  output logic [31:0]      mem_addr_out,
  output logic [31:0]      mem_wdata_out,
  output logic             mem_we_out,
  // host memory access, allowed only while host boot stalls the cpu
  input  wire logic        host_mem_we_in,
  input  wire logic        host_mem_re_in,
  output logic             host_mem_grant_out,
  // sdram init
  output logic             sdram_init_start_out,
  input  wire logic        sdram_init_done_in,
  // core state
  output logic             core_in_reset_out,
  output logic             test_in_reset_out,
  output logic             cpu_run_out,
  output logic [31:0]      cpu_pc_out,
  output logic             use_pci_out,
  output logic [1:0]       pll_mult_sel_out,
  output logic [1:0]       debug_mode_out,
  output logic             core_div4_clock_out,
  output logic             core_div6_clock_out
);
  // ****************************************************************
  // pin synchronisers: three stages, a change counts on agreement
  // ****************************************************************
  localparam int NPIN = 4;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] s1_q, s2_q, s3_q, pin_q;
  assign pin_raw = {link.core_reset_n, link.test_reset_n,
                    link.host_to_cpu_doorbell, link.doorbell_clear};

  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_sync
      always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          s1_q[g]  <= 1'b0;
          s2_q[g]  <= 1'b0;
          s3_q[g]  <= 1'b0;
          pin_q[g] <= 1'b0;
        end else begin
          s1_q[g] <= pin_raw[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          if (s2_q[g] == s3_q[g]) begin
            pin_q[g] <= s3_q[g];
          end
        end
      end
    end
  endgenerate

  logic core_rst_n, test_rst_n, bell, bell_clr;
  assign core_rst_n = pin_q[3];
  // pull-down makes undriven reset count as asserted
  assign test_rst_n = pin_q[2];
  assign bell       = pin_q[1];
  assign bell_clr   = pin_q[0];
  logic test_prev_q, bell_prev_q;

  // ****************************************************************
  // straps and debug mode
  // ****************************************************************
  logic [1:0] boot_q;
  logic       sdram_q;
  // straps follow pins in reset, frozen after release
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      boot_q           <= rbcm_pkg::BOOT_NONE;
      sdram_q          <= 1'b0;
      use_pci_out      <= 1'b0;
      pll_mult_sel_out <= rbcm_pkg::RATIO_BYPASS;
    end else if (!core_rst_n) begin
      boot_q           <= link.boot_mode_strap;
      sdram_q          <= link.sdram_present;
      // strap 0 host port, 1 pci
      use_pci_out      <= link.pci_sel_strap;
      // reserved code falls back to bypass
      pll_mult_sel_out <= (link.pll_ratio_sel == rbcm_pkg::RATIO_RSVD) ?
                          rbcm_pkg::RATIO_BYPASS : link.pll_ratio_sel;
    end
  end

  // test domain held while its reset is low
  // latch debug pins on the rising test reset after core release
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      test_prev_q       <= 1'b0;
      debug_mode_out    <= 2'h0;
      test_in_reset_out <= 1'b1;
    end else begin
      test_prev_q       <= test_rst_n;
      test_in_reset_out <= !test_rst_n;
      if (test_rst_n && !test_prev_q && core_rst_n) begin
        debug_mode_out <= link.debug_mode_pin;
      end
    end
  end

  // ****************************************************************
  // boot sequencer
  // ****************************************************************
  localparam int BW    = $clog2(COPY_BYTES) + 1;
  rbcm_pkg::rbcm_state_t st_q;
  logic [BW-1:0] byte_q;
  logic [23:0]   word_q;
  logic          rd_pend_q;

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bell_prev_q <= 1'b0;
    end else begin
      bell_prev_q <= bell;
    end
  end

  // doorbell pending only once running, set wins over clear
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      link.doorbell_pending <= 1'b0;
    end else if (bell && !bell_prev_q && st_q == rbcm_pkg::RBCM_S_RUN) begin
      link.doorbell_pending <= 1'b1;
    end else if (bell_clr) begin
      link.doorbell_pending <= 1'b0;
    end
  end

  // core held in reset, release starts chosen boot
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_q                 <= rbcm_pkg::RBCM_S_RESET;
      byte_q               <= '0;
      word_q               <= '0;
      rd_pend_q            <= 1'b0;
      rom_rd_out           <= 1'b0;
      rom_addr_out         <= rbcm_pkg::ROM_BASE;
      mem_we_out           <= 1'b0;
      mem_addr_out         <= rbcm_pkg::BOOT_ADDR;
      mem_wdata_out        <= 32'h0000_0000;
      sdram_init_start_out <= 1'b0;
    end else if (!core_rst_n) begin
      st_q       <= rbcm_pkg::RBCM_S_RESET;
      byte_q     <= '0;
      rd_pend_q  <= 1'b0;
      rom_rd_out <= 1'b0;
      mem_we_out <= 1'b0;
      sdram_init_start_out <= 1'b0;
    end else begin
      mem_we_out           <= 1'b0;
      rom_rd_out           <= 1'b0;
      sdram_init_start_out <= 1'b0;
      case (st_q)
        rbcm_pkg::RBCM_S_RESET: begin
          case (boot_q)
            // host boot: cpu stalled, rest runs
            rbcm_pkg::BOOT_HOST: st_q <= rbcm_pkg::RBCM_S_STALL;
            rbcm_pkg::BOOT_ROM:  st_q <= rbcm_pkg::RBCM_S_COPY;
            default: begin
              st_q <= sdram_q ? rbcm_pkg::RBCM_S_SDRAM : rbcm_pkg::RBCM_S_RUN;
              sdram_init_start_out <= sdram_q;
            end
          endcase
        end
        rbcm_pkg::RBCM_S_STALL: begin
          if (bell && !bell_prev_q) begin
            st_q <= rbcm_pkg::RBCM_S_RUN;
          end
        end
        rbcm_pkg::RBCM_S_COPY: begin
          if (rd_pend_q) begin
            rd_pend_q <= 1'b0;
            byte_q    <= byte_q + BW'(1);
            if (byte_q[1:0] == 2'h3) begin
              // four bytes make one word in system byte order
              mem_we_out    <= 1'b1;
              mem_addr_out  <= rbcm_pkg::BOOT_ADDR + 32'(byte_q & ~BW'(3));
              mem_wdata_out <= BIG_ENDIAN ? {word_q, rom_data_in} :
                               {rom_data_in, word_q[7:0], word_q[15:8],
                                word_q[23:16]};
              // one block, then run from address 0
              if (byte_q == BW'(COPY_BYTES - 1)) begin
                st_q <= rbcm_pkg::RBCM_S_RUN;
              end
            end else begin
              word_q <= {word_q[15:0], rom_data_in};
            end
          end else begin
            rom_rd_out   <= 1'b1;
            rom_addr_out <= rbcm_pkg::ROM_BASE + 32'(byte_q);
            rd_pend_q    <= 1'b1;
          end
        end
        rbcm_pkg::RBCM_S_SDRAM: begin
          if (sdram_init_done_in) begin
            st_q <= rbcm_pkg::RBCM_S_RUN;
          end
        end
        rbcm_pkg::RBCM_S_RUN: st_q <= rbcm_pkg::RBCM_S_RUN;
        default: st_q <= rbcm_pkg::RBCM_S_RESET;
      endcase
    end
  end

  // ****************************************************************
  // core outputs
  // ****************************************************************
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      core_in_reset_out  <= 1'b1;
      cpu_run_out        <= 1'b0;
      cpu_pc_out         <= rbcm_pkg::BOOT_ADDR;
      link.cpu_stalled   <= 1'b1;
      host_mem_grant_out <= 1'b0;
    end else begin
      core_in_reset_out <= !core_rst_n;
      cpu_run_out       <= core_rst_n && st_q == rbcm_pkg::RBCM_S_RUN;
      cpu_pc_out        <= rbcm_pkg::BOOT_ADDR;
      link.cpu_stalled  <= !(core_rst_n && st_q == rbcm_pkg::RBCM_S_RUN);
      // host reads and writes memory during host stall
      host_mem_grant_out <= core_rst_n && st_q == rbcm_pkg::RBCM_S_STALL &&
                            (host_mem_we_in || host_mem_re_in);
    end
  end

  // aux clocks at a quarter and a sixth of core clock
  rbcm_clk_div #(.DIV(rbcm_pkg::AUX_DIV_A)) u_div4 (
    .sys_clk_in (sys_clk_in),
    .reset_n_in (reset_n_in),
    .clk_out    (core_div4_clock_out)
  );
  rbcm_clk_div #(.DIV(rbcm_pkg::AUX_DIV_B)) u_div6 (
    .sys_clk_in (sys_clk_in),
    .reset_n_in (reset_n_in),
    .clk_out    (core_div6_clock_out)
  );
endmodule : rbcm_device
`default_nettype wire

// ### rtl/rbcm_pkg.sv
// package: constants and types for reset, boot and clock-mode control
`default_nettype none
package rbcm_pkg;
  // ****************************************************************
  // clock ratio straps
  // ****************************************************************
  localparam logic [1:0] RATIO_BYPASS = 2'h0;
  localparam logic [1:0] RATIO_X6     = 2'h1;
  localparam logic [1:0] RATIO_X12    = 2'h2;
  localparam logic [1:0] RATIO_RSVD   = 2'h3;
  localparam int         MULT_X6      = 6;
  localparam int         MULT_X12     = 12;
  localparam int         AUX_DIV_A    = 4;
  localparam int         AUX_DIV_B    = 6;
  // ****************************************************************
  // boot modes
  // ****************************************************************
  localparam logic [1:0] BOOT_NONE = 2'h0;
  localparam logic [1:0] BOOT_HOST = 2'h1;
  localparam logic [1:0] BOOT_ROM  = 2'h2;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_HZ          = 25_000_000;
  localparam int LOCK_TYP_MS     = 75;
  localparam int LOCK_STRETCH_PC = 150;
  // worst lock = typical plus 150 percent of it, rounded up to cycles
  localparam longint LOCK_CYCLES =
    (longint'(LOCK_TYP_MS) * (100 + LOCK_STRETCH_PC) * CLK_HZ
     + 100_000 - 1) / 100_000;
  // ****************************************************************
  // rom copy and addresses
  // ****************************************************************
  localparam int          ROM_COPY_BYTES = 1024;
  localparam logic [31:0] BOOT_ADDR      = 32'h0000_0000;
  localparam logic [31:0] ROM_BASE       = 32'h0000_0000;
  // ****************************************************************
  // controller register offsets and control bits
  // ****************************************************************
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STRAP  = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam int CTRL_CORE_REL   = 0;
  localparam int CTRL_TEST_REL   = 1;
  localparam int CTRL_DOORBELL   = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  typedef enum logic [2:0] {
    RBCM_S_RESET  = 3'b000,
    RBCM_S_LOCK   = 3'b001,
    RBCM_S_STALL  = 3'b011,
    RBCM_S_COPY   = 3'b010,
    RBCM_S_SDRAM  = 3'b110,
    RBCM_S_RUN    = 3'b111
  } rbcm_state_t;
endpackage : rbcm_pkg
`default_nettype wire

// ### rtl/rbcm_link_if.sv
// interface: pins between the sequencer device and its controller
`default_nettype none
interface rbcm_link_if;
  logic       core_reset_n;
  logic       test_reset_n_o;
  logic       test_reset_n_oe;
  logic [1:0] pll_ratio_sel;
  logic [1:0] boot_mode_strap;
  logic       pci_sel_strap;
  logic       sdram_present;
  logic [1:0] debug_mode_pin;
  logic       host_to_cpu_doorbell;
  logic       doorbell_clear;
  logic       doorbell_pending;
  logic       cpu_stalled;
  // test reset is pulled down when nobody drives it
  wire        test_reset_n = test_reset_n_oe ? test_reset_n_o : 1'b0;

  modport device (
    input  core_reset_n, test_reset_n, pll_ratio_sel, boot_mode_strap,
    input  pci_sel_strap, sdram_present, debug_mode_pin,
    input  host_to_cpu_doorbell, doorbell_clear,
    output doorbell_pending, cpu_stalled
  );
  modport host (
    output core_reset_n, test_reset_n_o, test_reset_n_oe, pll_ratio_sel,
    output boot_mode_strap, pci_sel_strap, sdram_present, debug_mode_pin,
    output host_to_cpu_doorbell, doorbell_clear,
    input  doorbell_pending, cpu_stalled
  );
endinterface : rbcm_link_if
`default_nettype wire

// ### rtl/rbcm_clk_div.sv
// module: square-ish clock divider driven from core clock, register output
`default_nettype none
module rbcm_clk_div #(
  parameter int DIV = 4
) (
  input  wire logic sys_clk_in,
  input  wire logic reset_n_in,
  output logic      clk_out
);
  localparam int W = $clog2(DIV);
  logic [W-1:0] cnt_q;

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_q   <= '0;
      clk_out <= 1'b0;
    end else begin
      if (cnt_q == W'(DIV - 1)) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + W'(1);
      end
      clk_out <= (cnt_q < W'(DIV / 2));
    end
  end
endmodule : rbcm_clk_div
`default_nettype wire

// ### rtl/rbcm_host.sv
// module: controller end, drives resets, straps and doorbell from registers
`default_nettype none
module rbcm_host #(
  parameter longint LOCK_CYCLES = rbcm_pkg::LOCK_CYCLES
) (
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  // register port
  input  wire logic [3:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic [31:0]      rdata_out,
  // link
  rbcm_link_if.host        link
);
  logic [31:0] ctrl_q;
  logic [7:0]  strap_q;
  logic [31:0] lock_q;
  logic        locked_q;
  logic        st1_q, st2_q, st3_q, stall_q;

  // straps: [1:0] ratio, [3:2] boot, [4] pci, [5] sdram, [7:6] debug
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl_q  <= rbcm_pkg::CTRL_RESET;
      strap_q <= 8'h00;
    end else if (wr_in && addr_in == rbcm_pkg::REG_CTRL) begin
      ctrl_q <= wdata_in;
    end else if (wr_in && addr_in == rbcm_pkg::REG_STRAP) begin
      strap_q <= (wdata_in[1:0] == rbcm_pkg::RATIO_RSVD) ?
                 {wdata_in[7:2], rbcm_pkg::RATIO_BYPASS} : wdata_in[7:0];
    end
  end

  // count worst lock time after each strap write that picks a multiplied ratio
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lock_q   <= '0;
      locked_q <= 1'b0;
    end else if (wr_in && addr_in == rbcm_pkg::REG_STRAP) begin
      lock_q   <= '0;
      locked_q <= (wdata_in[1:0] == rbcm_pkg::RATIO_BYPASS) ||
                  (wdata_in[1:0] == rbcm_pkg::RATIO_RSVD);
    end else if (!locked_q) begin
      lock_q <= lock_q + 32'h1;
      if (64'(lock_q) >= 64'(LOCK_CYCLES - 1)) begin
        locked_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st1_q   <= 1'b1;
      st2_q   <= 1'b1;
      st3_q   <= 1'b1;
      stall_q <= 1'b1;
    end else begin
      st1_q <= link.cpu_stalled;
      st2_q <= st1_q;
      st3_q <= st2_q;
      if (st2_q == st3_q) begin
        stall_q <= st3_q;
      end
    end
  end

  // both resets held from power-up until software releases them
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      link.core_reset_n         <= 1'b0;
      link.test_reset_n_o       <= 1'b0;
      link.test_reset_n_oe      <= 1'b1;
      link.pll_ratio_sel        <= rbcm_pkg::RATIO_BYPASS;
      link.boot_mode_strap      <= rbcm_pkg::BOOT_NONE;
      link.pci_sel_strap        <= 1'b0;
      link.sdram_present        <= 1'b0;
      link.debug_mode_pin       <= 2'h0;
      link.host_to_cpu_doorbell <= 1'b0;
      link.doorbell_clear       <= 1'b0;
    end else begin
      link.pll_ratio_sel   <= strap_q[1:0];
      link.boot_mode_strap <= strap_q[3:2];
      link.pci_sel_strap   <= strap_q[4];
      link.sdram_present   <= strap_q[5];
      link.debug_mode_pin  <= strap_q[7:6];
      // core released only once the pll has locked
      link.core_reset_n    <= ctrl_q[rbcm_pkg::CTRL_CORE_REL] && locked_q;
      // test reset rises only after core release
      link.test_reset_n_o  <= ctrl_q[rbcm_pkg::CTRL_TEST_REL] &&
                              link.core_reset_n;
      // pin floats low until test release is asked for
      link.test_reset_n_oe <= ctrl_q[rbcm_pkg::CTRL_TEST_REL];
      link.host_to_cpu_doorbell <= ctrl_q[rbcm_pkg::CTRL_DOORBELL];
      // cpu side clears the doorbell once running
      link.doorbell_clear  <= link.doorbell_pending && !stall_q;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_out <= 32'h0000_0000;
    end else if (rd_in) begin
      case (addr_in)
        rbcm_pkg::REG_CTRL:   rdata_out <= ctrl_q;
        rbcm_pkg::REG_STRAP:  rdata_out <= {24'h000000, strap_q};
        rbcm_pkg::REG_STATUS: rdata_out <= {29'h0, link.doorbell_pending,
                                            stall_q, locked_q};
        default:              rdata_out <= 32'h0000_0000;
      endcase
    end else begin
      rdata_out <= 32'h0000_0000;
    end
  end
endmodule : rbcm_host
`default_nettype wire

// ### testbench/rbcm_link_props.sv
// checker: timing relations on the link between controller and device
`default_nettype none
module rbcm_link_props #(
  parameter int COPY_BYTES = rbcm_pkg::ROM_COPY_BYTES
) (
  // clock and reset
  input wire logic       sys_clk_in,
  input wire logic       reset_n_in,
  // link signals
  input wire logic       core_reset_n,
  input wire logic       test_reset_n,
  input wire logic       test_reset_n_oe,
  input wire logic [1:0] boot_mode_strap,
  input wire logic       sdram_present,
  input wire logic       host_to_cpu_doorbell,
  input wire logic       doorbell_pending,
  input wire logic       cpu_stalled
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  // ****************************************************************
  // helper: cycles since core release, saturating
  // ****************************************************************
  logic [12:0] rel_q;
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) rel_q <= 13'h0000;
    else if (!core_reset_n) rel_q <= 13'h0000;
    else if (rel_q != 13'h1FFF) rel_q <= rel_q + 13'h0001;
  end
  wire host_b = boot_mode_strap == rbcm_pkg::BOOT_HOST;
  // ****************************************************************
  // properties
  // ****************************************************************
  property p_rst_held;
    $rose(reset_n_in) |-> !core_reset_n && !test_reset_n;
  endproperty
  a_rst_held: assert property (p_rst_held)
    else $error("resets not asserted after power-on");
  property p_pulldown;
    !test_reset_n_oe |-> !test_reset_n;
  endproperty
  a_pulldown: assert property (p_pulldown)
    else $error("undriven test reset not low");
  property p_trst_order;
    $rose(test_reset_n) |-> core_reset_n;
  endproperty
  a_trst_order: assert property (p_trst_order)
    else $error("test reset rose before core release");
  property p_core_stall;
    !core_reset_n |-> cpu_stalled;
  endproperty
  a_core_stall: assert property (p_core_stall)
    else $error("cpu not stalled in core reset");
  property p_host_go;
    $rose(host_to_cpu_doorbell) && cpu_stalled && host_b
      && rel_q > 13'h0010 |-> ##[1:12] !cpu_stalled;
  endproperty
  a_host_go: assert property (p_host_go)
    else $error("doorbell did not end host boot");
  property p_pend_run;
    $rose(doorbell_pending) |-> !$past(cpu_stalled, 12);
  endproperty
  a_pend_run: assert property (p_pend_run)
    else $error("boot doorbell recorded as pending");
  property p_other_hold;
    $rose(host_to_cpu_doorbell) && cpu_stalled && !host_b
      |=> cpu_stalled [*8];
  endproperty
  a_other_hold: assert property (p_other_hold)
    else $error("doorbell ended stall outside host boot");
  property p_rom_len;
    $fell(cpu_stalled) && boot_mode_strap == rbcm_pkg::BOOT_ROM
      |-> rel_q >= 2 * COPY_BYTES;
  endproperty
  a_rom_len: assert property (p_rom_len)
    else $error("rom boot ended before copy could finish");
  property p_none_run;
    $rose(core_reset_n) && boot_mode_strap == rbcm_pkg::BOOT_NONE
      && !sdram_present |-> ##[1:16] !cpu_stalled;
  endproperty
  a_none_run: assert property (p_none_run)
    else $error("no-boot start late");
endmodule : rbcm_link_props
`default_nettype wire

// ### testbench/tb_reset_boot_and_clock_mode_control.sv
// testbench: controller and device joined over the link
`default_nettype none
module tb_reset_boot_and_clock_mode_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LOCK = 20;
  localparam int CB   = rbcm_pkg::ROM_COPY_BYTES;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rd_q = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, maddr, mdata, raddr, pc, rm;
  logic        rrd, mwe, grant, sd_st, cin, tin, run, pci, c4, c6, a4;
  logic [1:0]  mult, dbgm, dbg;
  logic [7:0]  rom_d;
  logic        hwe = 1'b0, hre = 1'b0, sd_done = 1'b0;
  logic [7:0]  rom [CB];
  logic [31:0] exp_q[$], msk_q[$];
  logic [63:0] mem_q[$];
  int          err_count = 0, total_checks = 0, seed = 10, sd_n = 0;
  always #20 clk = ~clk;
  rbcm_link_if lnk ();
  rbcm_host #(.LOCK_CYCLES(LOCK)) i_rbcm_host (.sys_clk_in(clk),
    .reset_n_in(rst_n), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
    .rd_in(rd), .rdata_out(rdata), .link(lnk));
  rbcm_device #(.COPY_BYTES(CB)) i_rbcm_device (.sys_clk_in(clk),
    .reset_n_in(rst_n), .link(lnk), .rom_addr_out(raddr),
    .rom_rd_out(rrd), .rom_data_in(rom_d), .mem_addr_out(maddr),
    .mem_wdata_out(mdata), .mem_we_out(mwe), .host_mem_we_in(hwe),
    .host_mem_re_in(hre), .host_mem_grant_out(grant),
    .sdram_init_start_out(sd_st), .sdram_init_done_in(sd_done),
    .core_in_reset_out(cin), .test_in_reset_out(tin), .cpu_run_out(run),
    .cpu_pc_out(pc), .use_pci_out(pci), .pll_mult_sel_out(mult),
    .debug_mode_out(dbgm), .core_div4_clock_out(c4),
    .core_div6_clock_out(c6));
  rbcm_link_props #(.COPY_BYTES(CB)) u_props (.sys_clk_in(clk),
    .reset_n_in(rst_n), .core_reset_n(lnk.core_reset_n),
    .test_reset_n(lnk.test_reset_n), .test_reset_n_oe(lnk.test_reset_n_oe),
    .boot_mode_strap(lnk.boot_mode_strap),
    .sdram_present(lnk.sdram_present),
    .host_to_cpu_doorbell(lnk.host_to_cpu_doorbell),
    .doorbell_pending(lnk.doorbell_pending), .cpu_stalled(lnk.cpu_stalled));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(string nm, logic [63:0] seen, logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask : check
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done
  task automatic wrr(logic [3:0] a, logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrr
  task automatic rdr(logic [3:0] a, logic [31:0] e, logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask : rdr
  // host memory write then read, back to back
  task automatic macc(logic e);
    @(posedge clk);
    hwe <= 1'b1;
    @(posedge clk);
    hwe <= 1'b0;
    hre <= 1'b1;
    @(posedge clk);
    hre <= 1'b0;
    check("grant wr", grant, e);
    @(posedge clk);
    check("grant rd", grant, e);
  endtask : macc
  task automatic wait_run(int n);
    for (int i = 0; i < n && run !== 1'b1; i++) @(posedge clk);
    check("run", run, 1'b1);
    check("pc", pc, rbcm_pkg::BOOT_ADDR);
  endtask : wait_run
  task automatic boot(logic [1:0] r, logic [1:0] md, logic p, logic s);
    dbg = 2'($random(seed));
    repeat (2) @(posedge clk);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    check("core rst", cin, 1'b1);
    check("test rst", tin, 1'b1);
    wrr(rbcm_pkg::REG_STRAP, {24'h0, dbg, s, p, md, r});
    repeat (LOCK + 8) @(posedge clk);
    rdr(rbcm_pkg::REG_STATUS, 32'h3, 32'h3);
    wrr(rbcm_pkg::REG_CTRL, 32'h1);
    for (int i = 0; i < 20 && cin !== 1'b0; i++) @(posedge clk);
    check("ratio", mult, r == 2'h3 ? 2'h0 : r);
    check("pci", pci, p);
  endtask : boot
  // ****************************************************************
  // result watcher and rom model
  // ****************************************************************
  assign rom_d = rrd ? rom[raddr[9:0]] : ~rom[raddr[9:0]];
  always @(posedge clk) begin
    rd_q <= rd;
    if (sd_st) sd_n++;
    if (rd_q) begin
      rm = msk_q.pop_front();
      check("rdata", rdata & rm, exp_q.pop_front());
    end
    if (mwe && mem_q.size() == 0) check("extra write", 1'b1, 1'b0);
    else if (mwe) check("mem", {maddr, mdata}, mem_q.pop_front());
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("watchdog expired");
    test_done();
  end
  initial begin
    for (int i = 0; i < CB; i++) rom[i] = 8'($random(seed));
    boot(2'h1, rbcm_pkg::BOOT_HOST, 1'($random(seed)), 1'b0);
    repeat (30) @(posedge clk);
    check("host stall", lnk.cpu_stalled, 1'b1);
    macc(1'b1);
    wrr(rbcm_pkg::REG_CTRL, 32'h5);
    wait_run(40);
    rdr(rbcm_pkg::REG_STATUS, 32'h0, 32'h4);
    wrr(rbcm_pkg::REG_CTRL, 32'h3);
    repeat (20) @(posedge clk);
    check("test rel", tin, 1'b0);
    check("debug", dbgm, dbg);
    wrr(rbcm_pkg::REG_CTRL, 32'h7);
    repeat (7) @(posedge clk);
    rdr(rbcm_pkg::REG_STATUS, 32'h4, 32'h6);
    repeat (10) @(posedge clk);
    rdr(rbcm_pkg::REG_STATUS, 32'h0, 32'h4);
    rdr(4'hF, 32'h0, 32'hFFFF_FFFF);
    $display("test host boot done");
    for (int i = 0; i < CB / 4; i++)
      mem_q.push_back({32'(4 * i), rom[4*i+3], rom[4*i+2], rom[4*i+1],
                       rom[4*i]});
    boot(2'h2, rbcm_pkg::BOOT_ROM, 1'b0, 1'b0);
    repeat (100) @(posedge clk);
    check("rom stall", lnk.cpu_stalled, 1'b1);
    wait_run(2 * CB + 100);
    check("copy left", mem_q.size(), 0);
    $display("test rom boot done");
    boot(2'h3, rbcm_pkg::BOOT_NONE, 1'b0, 1'b1);
    wrr(rbcm_pkg::REG_CTRL, 32'h5);
    repeat (20) @(posedge clk);
    check("sdram stall", lnk.cpu_stalled, 1'b1);
    macc(1'b0);
    sd_done <= 1'b1;
    wait_run(20);
    check("sdram start", sd_n, 1);
    $display("test sdram boot done");
    sd_done <= 1'b0;
    boot(2'h0, rbcm_pkg::BOOT_NONE, 1'b0, 1'b0);
    wait_run(20);
    check("test held", tin, 1'b1);
    check("test pin", lnk.test_reset_n, 1'b0);
    a4 = c4;
    repeat (2) @(posedge clk);
    check("div4", c4, !a4);
    a4 = c6;
    repeat (3) @(posedge clk);
    check("div6", c6, !a4);
    $display("test direct boot done");
    test_done();
  end
endmodule : tb_reset_boot_and_clock_mode_control
`default_nettype wire
